/* cem_cfg_mem.sv */
`default_nettype none
module cem_cfg_mem #(
    parameter int FB = 16
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        rd_i,
    input  wire logic [0:0]  frame_i,
    input  wire logic [3:0]  bit_i,
    input  wire logic        arm_i,
    input  wire logic [0:0]  arm_frame_i,
    input  wire logic [3:0]  arm_bit_i,
    input  wire logic        flag_i,
    output logic             bit_o,
    output logic [15:0]      crc_o,
    output logic             armed_o,
    output logic             reconfig_request_n_o
);
    logic [0:0]  af_q;
    logic [3:0]  ab_q;
    logic        flag_q;
    logic        hit;
    logic        val;
    logic [15:0] crc;
    function automatic logic d_bit(int f, int b);
        return 1'((f * 7 + b * 13) >> 2);
    endfunction
    function automatic logic [15:0] crc_of(int f);
        logic [15:0] r;
        r = 16'h0000;
        for (int b = 0; b < FB; b++)
            r = {r[14:0], d_bit(f, b)} ^ (r[15] ? 16'h1021 : 16'h0000);
        return r;
    endfunction
    // one-shot upset; unsampled lines show the inverse value
    always_comb begin
        hit = armed_o && frame_i == af_q && bit_i == ab_q;
        val = d_bit(int'(frame_i), int'(bit_i)) ^ hit;
        crc = crc_of(int'(frame_i));
        bit_o = rd_i ? val : ~val;
        crc_o = (rd_i && bit_i == 4'(FB - 1)) ? crc : ~crc;
    end
    always_ff @(posedge clk_i) begin
        flag_q <= rst_i ? 1'b0 : flag_i;
        reconfig_request_n_o <= rst_i || !(flag_i && !flag_q);
        if (rst_i) begin
            armed_o <= 1'b0;
        end else if (arm_i) begin
            armed_o <= 1'b1;
            af_q <= arm_frame_i;
            ab_q <= arm_bit_i;
        end else if (rd_i && hit) begin
            armed_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* cem_crc_monitor.sv */
`default_nettype none

// Notes on behaviour
// - With checking enabled, checking starts on its own once the device is in user mode.
// - A frame error raises the fault flag only after the search ends and the message register holds the result.
// - After each report the fault flag goes low and stays low for at least 32 checker ticks.
// - An error in a following frame raises the flag again once the message register holds the new result.
// - Once started the checker loops over all frames without end until reset.
// - The checker rate is the oscillator divided by two to the power n; the divider counts clk_sys_i cycles instead.
// - The exponent n is clamped to the range 1 to 8, giving divisors 2 to 256.
// - The crc is computed and compared frame by frame at the checker rate.
// - Every detected error rewrites the message register, replacing any unread content.
// - Message updates are spaced by at least the least interval for the device size.
// - With checking enabled the fault flag is driven onto the dual-purpose pin.
// - A 16-bit syndrome is kept per frame and any non-zero value leads to the fault flag.
// - The 46-bit message holds type, location and syndrome and is readable by test port or core port.
module cem_crc_monitor #(
    parameter int unsigned        FRAME_BITS = 64,
    parameter int unsigned        NUM_FRAMES = 16,
    parameter cem_pkg::cem_size_e DEV_SIZE   = cem_pkg::SIZE_SMALL
) (
    input  wire logic                                    clk_sys_i,
    input  wire logic                                    sys_rst_i,
    input  wire logic                                    err_chk_en_i,
    input  wire logic                                    user_mode_i,
    input  wire logic [3:0]                              div_exp_i,
    output logic                                         cfg_rd_o,
    output logic [((NUM_FRAMES > 1) ? $clog2(NUM_FRAMES) : 1)-1:0] cfg_frame_o,
    output logic [$clog2(FRAME_BITS)-1:0]                cfg_bit_idx_o,
    input  wire logic                                    cfg_bit_i,
    input  wire logic [cem_pkg::SYN_W-1:0]               cfg_crc_i,
    output logic                                         crc_error_o,
    output logic                                         crc_error_pin_o,
    output logic                                         crc_error_pin_oe_o,
    output logic [cem_pkg::SYN_W-1:0]                    syndrome_o,
    output logic [cem_pkg::MSG_W-1:0]                    msg_o,
    output logic                                         running_o,
    input  wire logic                                    core_capture_i,
    input  wire logic                                    core_shift_i,
    output logic                                         core_sdo_o,
    input  wire logic [cem_pkg::TP_IR_W-1:0]             tp_ir_i,
    input  wire logic                                    tp_capture_i,
    input  wire logic                                    tp_shift_i,
    output logic                                         tp_sdo_o
);
    import cem_pkg::*;

    localparam int unsigned   PW       = $clog2(FRAME_BITS);
    localparam int unsigned   FW       = (NUM_FRAMES > 1) ? $clog2(NUM_FRAMES) : 1;
    localparam logic [PW-1:0] LAST_BIT = PW'(FRAME_BITS - 1);
    localparam logic [FW-1:0] LAST_FRM = FW'(NUM_FRAMES - 1);
    localparam int unsigned   GAP_CYC  = (DEV_SIZE == SIZE_LARGE)  ? UPD_GAP_LARGE_CYC :
                                         (DEV_SIZE == SIZE_MEDIUM) ? UPD_GAP_MEDIUM_CYC : UPD_GAP_SMALL_CYC;
    localparam int unsigned   GW       = $clog2(GAP_CYC + 1);
    localparam logic [GW-1:0] GAP_MAX  = GW'(GAP_CYC);

    typedef struct packed {
        cem_st_e          st;
        logic [SYN_W-1:0] crc;
        logic [SYN_W-1:0] syn;
        logic [SYN_W-1:0] srch;
        logic [PW-1:0]    pos;
        logic [PW-1:0]    k;
        logic [PW-1:0]    loc;
        logic [FW-1:0]    frm;
        cem_err_e         typ;
        logic [MSG_W-1:0] msg;
        logic             upd;
        logic             pend;
        logic             flag;
        logic             pin_en;
        logic [5:0]       fl_cnt;
        logic [GW-1:0]    gap;
    } cem_mon_s;

    cem_mon_s         q;
    cem_mon_s         d;
    logic             tick;
    logic [SYN_W-1:0] crc_nx;
    logic [SYN_W-1:0] syn_nx;
    logic [SYN_W-1:0] srch_nx;

    // remainder of the frame polynomial, one bit per step
    function automatic logic [SYN_W-1:0] crc_step(input logic [SYN_W-1:0] s, input logic b);
        crc_step = {s[SYN_W-2:0], b} ^ (s[SYN_W-1] ? CRC_POLY : 16'h0000);
    endfunction

    function automatic logic [FW-1:0] frm_next(input logic [FW-1:0] f);
        frm_next = (f == LAST_FRM) ? '0 : f + FW'(1);
    endfunction

    cem_tick_div u_div (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .run_i     (q.st != ST_IDLE),
        .div_exp_i (div_exp_i),
        .tick_o    (tick)
    );

    always_comb begin
        d       = q;
        d.upd   = 1'b0;
        crc_nx  = crc_step(q.crc, cfg_bit_i);
        syn_nx  = crc_nx ^ cfg_crc_i;
        srch_nx = crc_step(q.srch, 1'b0);
        if (q.gap != GAP_MAX) begin
            d.gap = q.gap + GW'(1);
        end
        d.pin_en = err_chk_en_i;
        case (q.st)
            ST_IDLE: begin
                if (err_chk_en_i && user_mode_i) begin
                    d.st  = ST_CHECK;
                    d.crc = '0;
                    d.pos = '0;
                    d.frm = '0;
                end
            end
            ST_CHECK: begin
                if (tick) begin
                    if (q.pos == LAST_BIT) begin
                        d.syn = syn_nx;
                        d.crc = '0;
                        d.pos = '0;
                        if (syn_nx != 16'h0000) begin
                            d.st   = ST_SEARCH;
                            d.k    = '0;
                            d.srch = 16'h0001;
                        end else begin
                            d.frm = frm_next(q.frm);
                        end
                    end else begin
                        d.crc = crc_nx;
                        d.pos = q.pos + PW'(1);
                    end
                end
            end
            ST_SEARCH: begin
                // walk single and adjacent-pair error syndromes from the frame end
                if (tick) begin
                    if (q.syn == q.srch) begin
                        d.typ = ERR_SINGLE;
                        d.loc = LAST_BIT - q.k;
                        d.st  = ST_REPORT;
                    end else if (q.k != LAST_BIT && q.syn == (q.srch ^ srch_nx)) begin
                        d.typ = ERR_DBL_ADJ;
                        d.loc = LAST_BIT - q.k - PW'(1);
                        d.st  = ST_REPORT;
                    end else if (q.k == LAST_BIT) begin
                        d.typ = ERR_OTHER;
                        d.loc = '0;
                        d.st  = ST_REPORT;
                    end else begin
                        d.k    = q.k + PW'(1);
                        d.srch = srch_nx;
                    end
                end
            end
            ST_REPORT: begin
                if (q.gap == GAP_MAX) begin
                    d.msg                                = '0;
                    d.msg[MSG_SYN_LSB +: SYN_W]          = q.syn;
                    d.msg[MSG_TYPE_LSB +: MSG_TYPE_W]    = q.typ;
                    d.msg[MSG_LOC_LSB +: MSG_LOC_W]      = MSG_LOC_W'(q.loc);
                    d.msg[MSG_FRM_LSB +: MSG_FRM_W]      = MSG_FRM_W'(q.frm);
                    d.upd                                = 1'b1;
                    d.pend                               = 1'b1;
                    d.gap                                = '0;
                    d.frm                                = frm_next(q.frm);
                    d.st                                 = ST_CHECK;
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase
        // fault flag: high for a few ticks, then a guaranteed low time
        if (tick) begin
            if (q.flag) begin
                if (q.fl_cnt == FLAG_HIGH_TICKS - 6'h01) begin
                    d.flag   = 1'b0;
                    d.fl_cnt = 6'h00;
                end else begin
                    d.fl_cnt = q.fl_cnt + 6'h01;
                end
            end else if (q.fl_cnt != FLAG_LOW_MIN_TICKS) begin
                d.fl_cnt = q.fl_cnt + 6'h01;
            end
        end
        // raise on a tick so the high time is whole ticks; never while the message is rewritten
        if (tick && !q.flag && q.pend && !d.upd && q.fl_cnt == FLAG_LOW_MIN_TICKS) begin
            d.flag   = 1'b1;
            d.fl_cnt = 6'h00;
            d.pend   = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            q        <= '0;
            q.fl_cnt <= FLAG_LOW_MIN_TICKS;
            q.gap    <= GAP_MAX;
        end else begin
            q <= d;
        end
    end

    assign cfg_rd_o           = tick && (q.st == ST_CHECK);
    assign cfg_frame_o        = q.frm;
    assign cfg_bit_idx_o      = q.pos;
    assign crc_error_o        = q.flag;
    assign crc_error_pin_o    = q.flag && q.pin_en;
    assign crc_error_pin_oe_o = q.pin_en;
    assign syndrome_o         = q.syn;
    assign msg_o              = q.msg;
    assign running_o          = (q.st != ST_IDLE);

    cem_msg_port #(
        .W (MSG_W)
    ) u_core_port (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .sel_i     (1'b1),
        .upd_i     (q.upd),
        .msg_i     (q.msg),
        .capture_i (core_capture_i),
        .shift_i   (core_shift_i),
        .sdo_o     (core_sdo_o)
    );

    cem_msg_port #(
        .W (MSG_W)
    ) u_tp_port (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .sel_i     (tp_ir_i == test_port_error_msg_read_instr),
        .upd_i     (q.upd),
        .msg_i     (q.msg),
        .capture_i (tp_capture_i),
        .shift_i   (tp_shift_i),
        .sdo_o     (tp_sdo_o)
    );

    // helper state watched only by the checks below
    logic [5:0]    low_ticks_q;
    logic          rep_seen_q;
    logic [GW-1:0] since_upd_q;
    logic          upd_seen_q;

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            low_ticks_q <= 6'h00;
            rep_seen_q  <= 1'b0;
            since_upd_q <= '0;
            upd_seen_q  <= 1'b0;
        end else begin
            if (q.flag) begin
                low_ticks_q <= 6'h00;
                rep_seen_q  <= 1'b1;
            end else if (tick && low_ticks_q != 6'h3f) begin
                low_ticks_q <= low_ticks_q + 6'h01;
            end
            if (q.upd) begin
                since_upd_q <= '0;
                upd_seen_q  <= 1'b1;
            end else if (since_upd_q != GAP_MAX) begin
                since_upd_q <= since_upd_q + GW'(1);
            end
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence s_frame_end;
        q.st == ST_CHECK && tick && q.pos == LAST_BIT;
    endsequence

    sequence s_report_ready;
        tick && !q.flag && q.pend && !q.upd && q.fl_cnt == FLAG_LOW_MIN_TICKS;
    endsequence

    a_start_user: assert property (q.st == ST_IDLE && err_chk_en_i && user_mode_i |=> q.st == ST_CHECK)
        else $error("checker did not start in user mode");

    a_flag_after_msg: assert property ($rose(crc_error_o) |-> $past(q.pend) &&
                                       msg_o[MSG_TYPE_LSB +: MSG_TYPE_W] != ERR_NONE)
        else $error("fault flag rose without a settled message");

    a_flag_low_min: assert property ($rose(crc_error_o) && rep_seen_q |-> low_ticks_q >= 6'h20)
        else $error("fault flag low time shorter than 32 ticks");

    a_next_report: assert property (s_report_ready ##0 !d.upd |=> $rose(crc_error_o))
        else $error("pending message not reported");

    a_keep_running: assert property (q.st != ST_IDLE |=> q.st != ST_IDLE)
        else $error("checker stopped without reset");

    a_frame_syn: assert property (s_frame_end ##0 syn_nx != 16'h0000 |=>
                                  q.st == ST_SEARCH && syndrome_o != 16'h0000)
        else $error("non-zero syndrome did not start the search");

    a_msg_rewrite: assert property (q.upd |-> $past(q.st) == ST_REPORT &&
                                    msg_o[MSG_SYN_LSB +: SYN_W] == syndrome_o)
        else $error("message register not rewritten with the syndrome");

    a_upd_spacing: assert property (q.upd && upd_seen_q |-> since_upd_q == GAP_MAX)
        else $error("message updates closer than the least interval");

    a_pin_disabled: assert property (!err_chk_en_i |=> !crc_error_pin_oe_o && !crc_error_pin_o)
        else $error("fault pin driven while checking is disabled");

    a_idle_quiet: assert property (q.st == ST_IDLE |-> !crc_error_o && !q.pend)
        else $error("fault flag high while idle");

endmodule

`default_nettype wire

/* cem_crc_monitor_test.sv */
`default_nettype none
module cem_crc_monitor_test;
    timeunit 1ns;
    timeprecision 100ps;
    import cem_pkg::*;
    logic        clk, rst, en, um, ccap, csh, tcap, tsh, arm, rd, flag, pin, oe, run, csdo, tsdo, cbit, armed, rq_n;
    logic        fl_p, en_p, seen_fall, seen_upd, use_tp;
    logic [3:0]  div, ab, bidx;
    logic [0:0]  af, frm;
    logic [9:0]  tpir;
    logic [15:0] ccrc, syn;
    logic [45:0] msg, want, got, msg_p;
    logic [31:0] seed;
    logic [45:0] exp_q[$];
    int          bad_count, check_count, fb, bi, lo_n, hi_n, upd_n, t, n;
    event        rise_ev;
    logic [3:0]  t_div[5] = '{4'h0, 4'h1, 4'h3, 4'h8, 4'h9};
    cem_crc_monitor #(.FRAME_BITS(16), .NUM_FRAMES(2)) u_cem_crc_monitor (
        .clk_sys_i(clk), .sys_rst_i(rst), .err_chk_en_i(en), .user_mode_i(um), .div_exp_i(div),
        .cfg_rd_o(rd), .cfg_frame_o(frm), .cfg_bit_idx_o(bidx), .cfg_bit_i(cbit), .cfg_crc_i(ccrc),
        .crc_error_o(flag), .crc_error_pin_o(pin), .crc_error_pin_oe_o(oe), .syndrome_o(syn), .msg_o(msg),
        .running_o(run), .core_capture_i(ccap), .core_shift_i(csh), .core_sdo_o(csdo), .tp_ir_i(tpir),
        .tp_capture_i(tcap), .tp_shift_i(tsh), .tp_sdo_o(tsdo));
    cem_cfg_mem #(.FB(16)) u_cem_cfg_mem (
        .clk_i(clk), .rst_i(rst), .rd_i(rd), .frame_i(frm), .bit_i(bidx), .arm_i(arm), .arm_frame_i(af),
        .arm_bit_i(ab), .flag_i(flag), .bit_o(cbit), .crc_o(ccrc), .armed_o(armed), .reconfig_request_n_o(rq_n));
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [15:0] syn_of(int p);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < 16; i++)
            r = {r[14:0], 1'(i == p)} ^ (r[15] ? CRC_POLY : 16'h0000);
        return r;
    endfunction
    task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic gap_rd(output int c);
        c = 0;
        do begin
            @(negedge clk);
            c++;
        end while (!rd && c < 600);
    endtask
    task automatic unload(input logic tp, output logic [45:0] v);
        @(posedge clk);
        tpir <= tp ? test_port_error_msg_read_instr : ~test_port_error_msg_read_instr;
        ccap <= !tp;
        tcap <= tp;
        @(posedge clk);
        ccap <= 1'b0;
        tcap <= 1'b0;
        csh <= !tp;
        tsh <= tp;
        for (int i = 0; i < 46; i++) begin
            #1 v[i] = tp ? tsdo : csdo;
            @(posedge clk);
        end
        csh <= 1'b0;
        tsh <= 1'b0;
    endtask
    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    always @(negedge clk) begin
        if (rst) begin
            fb = 0;
            bi = 0;
            seen_fall = 0;
            seen_upd = 0;
        end else begin
            if (rd) begin
                chk("frame", fb, frm);
                chk("bit", bi, bidx);
                bi = (bi + 1) % 16;
                fb = (bi == 0) ? (fb + 1) % 2 : fb;
            end
            if (flag && !fl_p) begin
                want = exp_q.size() > 0 ? exp_q.pop_front() : '0;
                chk("msg", want, msg);
                chk("syndrome", want[15:0], syn);
                if (seen_fall) chk("low", 1, lo_n >= 64);
                hi_n = 0;
                -> rise_ev;
            end
            if (!flag && fl_p) begin
                chk("high", 8, hi_n);
                seen_fall = 1;
                lo_n = 0;
            end
            if (flag) hi_n++;
            else lo_n++;
            if (msg !== msg_p) begin
                if (seen_upd) chk("gap", 1, upd_n >= UPD_GAP_SMALL_CYC);
                seen_upd = 1;
                upd_n = 0;
            end
            upd_n++;
            if (en == en_p && flag == fl_p) chk("pin", {en, flag & en}, {oe, pin});
        end
        fl_p = flag;
        en_p = rst ? !en : en;
        msg_p = msg;
    end
    always begin
        @(rise_ev);
        unload(use_tp, got);
        chk("unloaded", want, got);
        use_tp = !use_tp;
    end
    initial begin
        repeat (40000) @(posedge clk);
        bad_count++;
        $display("watchdog expired");
        tally_and_finish();
    end
    initial begin
        {rst, en, um, ccap, csh, tcap, tsh, arm, use_tp} = 9'h101;
        {div, ab, af, tpir, seed} = {4'h1, 4'h0, 1'b0, 10'h000, 32'h418b};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        um <= 1'b1;
        repeat (100) begin
            @(negedge clk);
            chk("idle", 0, {run, rd, flag, oe});
        end
        $display("disabled test done");
        @(posedge clk);
        {rst, en, um} <= 3'b110;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (20) @(negedge clk);
        chk("early", 0, run);
        @(posedge clk) um <= 1'b1;
        repeat (2) @(negedge clk);
        chk("start", 1, run);
        $display("start test done");
        foreach (t_div[k]) begin
            @(posedge clk) div <= t_div[k];
            repeat (3) gap_rd(t);
            chk("period", 1 << (t_div[k] < 1 ? 1 : t_div[k] > 8 ? 8 : t_div[k]), t);
        end
        @(posedge clk) div <= 4'h1;
        $display("divider test done");
        for (int k = 0; k < 6; k++) begin
            seed = lfsr(seed);
            @(posedge clk);
            {arm, af, ab} <= {1'b1, seed[4:0]};
            exp_q.push_back({13'h0, seed[4], 10'h0, seed[3:0], 2'b01, syn_of(int'(seed[3:0]))});
            @(posedge clk) arm <= 1'b0;
            n = 0;
            do begin
                @(negedge clk);
                n++;
            end while (armed && n < 2000);
        end
        n = 0;
        while (exp_q.size() > 0 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        chk("drain", 0, exp_q.size());
        repeat (100) @(negedge clk);
        t = 0;
        repeat (100) begin
            @(negedge clk);
            t += rd;
        end
        chk("keeps running", {1'b1, 7'd50}, {run, 7'(t)});
        $display("error test done");
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(negedge clk);
        chk("reset", 0, {run, rd, flag, msg});
        $display("reset test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire

/* cem_msg_port.sv */
`default_nettype none

module cem_msg_port #(
    parameter int unsigned W = 46
) (
    input  wire logic         clk_sys_i,
    input  wire logic         sys_rst_i,
    input  wire logic         sel_i,
    input  wire logic         upd_i,
    input  wire logic [W-1:0] msg_i,
    input  wire logic         capture_i,
    input  wire logic         shift_i,
    output logic              sdo_o
);
    import cem_pkg::*;

    typedef struct packed {
        logic [W-1:0] upd;
        logic [W-1:0] sh;
        logic         pend;
    } cem_port_s;

    cem_port_s q;
    cem_port_s d;
    logic      cap;

    always_comb begin
        cap = sel_i && capture_i;
        d   = q;
        // update register held while the shift register samples it
        if (q.pend && !cap) begin
            d.upd  = msg_i;
            d.pend = 1'b0;
        end
        if (upd_i) begin
            d.pend = 1'b1;
        end
        if (cap) begin
            d.sh = q.upd;
        end else if (sel_i && shift_i) begin
            d.sh = {1'b0, q.sh[W-1:1]};
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sdo_o = q.sh[0];

    a_capture_copy: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (sel_i && capture_i) |=> (sdo_o == $past(q.upd[0])))
        else $error("shift register did not sample the update register");

endmodule

`default_nettype wire

/* cem_pkg.sv */
`default_nettype none

package cem_pkg;

    // clocking of this block
    localparam int unsigned SYS_CLK_HZ = 40_000_000;
    localparam int unsigned SYS_CLK_NS = 25;

    // checker clock: oscillator divided by two to the power n; cem_tick_div divides clk_sys_i instead
    localparam int unsigned OSC_HZ      = 100_000_000;
    localparam int unsigned CHK_MAX_HZ  = 50_000_000;
    localparam int unsigned CHK_MIN_HZ  = 390_000;
    localparam logic [3:0]  DIV_EXP_MIN = 4'h1;
    localparam logic [3:0]  DIV_EXP_MAX = 4'h8;
    localparam int unsigned DIV_CNT_W   = 8;

    // frame crc
    localparam int unsigned SYN_W    = 16;
    localparam logic [15:0] CRC_POLY = 16'h1021;

    // error message layout
    localparam int unsigned MSG_W        = 46;
    localparam int unsigned MSG_SYN_LSB  = 0;
    localparam int unsigned MSG_TYPE_LSB = 16;
    localparam int unsigned MSG_TYPE_W   = 2;
    localparam int unsigned MSG_LOC_LSB  = 18;
    localparam int unsigned MSG_LOC_W    = 14;
    localparam int unsigned MSG_FRM_LSB  = 32;
    localparam int unsigned MSG_FRM_W    = 14;

    typedef enum logic [1:0] {
        ERR_NONE    = 2'b00,
        ERR_SINGLE  = 2'b01,
        ERR_DBL_ADJ = 2'b10,
        ERR_OTHER   = 2'b11
    } cem_err_e;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_CHECK  = 2'b01,
        ST_SEARCH = 2'b10,
        ST_REPORT = 2'b11
    } cem_st_e;

    typedef enum logic [1:0] {
        SIZE_SMALL  = 2'b00,
        SIZE_MEDIUM = 2'b01,
        SIZE_LARGE  = 2'b10
    } cem_size_e;

    // fault flag timing, in checker ticks
    localparam logic [5:0] FLAG_LOW_MIN_TICKS = 6'h20;
    localparam logic [5:0] FLAG_HIGH_TICKS    = 6'h04;

    // least spacing of message updates per device size
    localparam real         UPD_GAP_SMALL_US  = 11.04;
    localparam real         UPD_GAP_MEDIUM_US = 14.88;
    localparam real         UPD_GAP_LARGE_US  = 19.64;
    localparam int unsigned UPD_GAP_SMALL_CYC  = int'($ceil(UPD_GAP_SMALL_US * 1000.0 / real'(SYS_CLK_NS)));
    localparam int unsigned UPD_GAP_MEDIUM_CYC = int'($ceil(UPD_GAP_MEDIUM_US * 1000.0 / real'(SYS_CLK_NS)));
    localparam int unsigned UPD_GAP_LARGE_CYC  = int'($ceil(UPD_GAP_LARGE_US * 1000.0 / real'(SYS_CLK_NS)));

    // test port instruction code, value arbitrary
    localparam int unsigned              TP_IR_W                        = 10;
    localparam logic [TP_IR_W-1:0]       test_port_error_msg_read_instr = 10'h017;

endpackage

`default_nettype wire

/* cem_tick_div.sv */
`default_nettype none

module cem_tick_div (
    input  wire logic       clk_sys_i,
    input  wire logic       sys_rst_i,
    input  wire logic       run_i,
    input  wire logic [3:0] div_exp_i,
    output logic            tick_o
);
    import cem_pkg::*;

    localparam int TICK_GAP_MAX = 300;

    typedef struct packed {
        logic [DIV_CNT_W-1:0] cnt;
        logic                 tick;
    } cem_div_s;

    cem_div_s             q;
    cem_div_s             d;
    logic [3:0]           exp_c;
    logic [DIV_CNT_W:0]   span;
    logic [DIV_CNT_W-1:0] mask;

    always_comb begin
        exp_c = div_exp_i;
        if (div_exp_i < DIV_EXP_MIN) begin
            exp_c = DIV_EXP_MIN;
        end else if (div_exp_i > DIV_EXP_MAX) begin
            exp_c = DIV_EXP_MAX;
        end
        span   = (DIV_CNT_W + 1)'(1) << exp_c;
        mask   = DIV_CNT_W'(span - (DIV_CNT_W + 1)'(1));
        d      = q;
        d.tick = run_i && ((q.cnt & mask) == mask);
        d.cnt  = run_i ? q.cnt + 8'h01 : 8'h00;
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick_o = q.tick;

    a_tick_spacing: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        tick_o |=> !tick_o)
        else $error("checker tick faster than half the clock");

    a_tick_bounded: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (run_i && tick_o) |-> ##[1:TICK_GAP_MAX] (tick_o || !run_i))
        else $error("checker tick slower than the largest divisor");

endmodule

`default_nettype wire
